//--- design/sac_map.svh
// register map, field positions and timing counts of the conversion control block
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_CTRL_ADDR 8'hE8
`define SAC_CTRL_PAGE 4'h0
`define SAC_PWR_ADDR 8'hBB
`define SAC_CTRL_RESET 8'h00
`define SAC_PWR_RESET 1'b0
`define SAC_BIT_EN 7
`define SAC_BIT_BURST 6
`define SAC_BIT_DONE 5
`define SAC_BIT_BUSY 4
`define SAC_BIT_WIN 3
`define SAC_BIT_LP 7
`define SAC_CM_SW 3'h0
`define SAC_CM_T0 3'h1
`define SAC_CM_T2 3'h2
`define SAC_CM_T3 3'h3
`define SAC_CLKS_8BIT 6'd11
`define SAC_CLKS_10BIT 6'd13
`define SAC_CLKS_12BIT 6'd52
`endif

//--- design/sac_pkg.sv
// types shared by the conversion control block
package sac_pkg;
	typedef enum logic {
		SAC_ST_IDLE = 1'b0,
		SAC_ST_CONV = 1'b1
	} sac_state_e;
	typedef logic [2:0] sac_src_t;
	typedef logic [5:0] sac_len_t;
endpackage

//--- design/sac_pass_timer.sv
// counts the SAR clocks of one conversion pass
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_pass_timer
	import sac_pkg::*;
#(
	parameter int LEN_W = 6
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic [LEN_W-1:0] len_i,
	output logic done_o
);
	logic [LEN_W-1:0] cnt_r;
	logic [LEN_W-1:0] cnt_nxt;
	logic done_r;
	logic done_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		if (start_i) begin
			cnt_nxt = len_i;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
		end
		done_nxt = (cnt_r == {{(LEN_W-1){1'b0}}, 1'b1});
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign done_o = done_r;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_len_8bit;
		start_i && len_i == `SAC_CLKS_8BIT |-> !done_o [*8] ##5 done_o;
	endproperty
	a_len_8bit: assert property (p_len_8bit) else $error("8-bit pass length wrong");

	property p_len_10bit;
		start_i && len_i == `SAC_CLKS_10BIT |-> ##14 done_o;
	endproperty
	a_len_10bit: assert property (p_len_10bit) else $error("10-bit pass length wrong");

	property p_len_12bit;
		start_i && len_i == `SAC_CLKS_12BIT |-> ##52 !done_o ##1 done_o;
	endproperty
	a_len_12bit: assert property (p_len_12bit) else $error("12-bit pass length wrong");
endmodule

//--- design/sac_conv_ctrl.sv
// start, burst sequencing, flags and control registers of the SAR converter
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_conv_ctrl
	import sac_pkg::*;
#(
	parameter int RPT_W = 7
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [3:0] sfr_page_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_rd_i,
	input wire logic sfr_bit_wr_i,
	input wire logic [7:0] sfr_bit_addr_i,
	input wire logic sfr_bit_val_i,
	input wire logic timer0_ovf_i,
	input wire logic timer2_ovf_i,
	input wire logic timer3_ovf_i,
	input wire logic external_start_pin_i,
	input wire logic mode_8bit_i,
	input wire logic mode_12bit_i,
	input wire logic [RPT_W-1:0] repeat_count_i,
	input wire logic [15:0] acc_result_i,
	input wire logic [15:0] greater_than_i,
	input wire logic [15:0] less_than_i,
	output logic [7:0] sfr_rdata_o,
	output logic conv_start_o,
	output logic converting_o,
	output logic analog_power_o,
	output logic low_power_select_o,
	output logic conversion_done_flag_o,
	output logic window_hit_flag_o
);
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic [7:0] ctrl_new;
	logic lp_r;
	logic lp_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	sac_state_e st_r;
	sac_state_e st_nxt;
	logic [RPT_W-1:0] left_r;
	logic [RPT_W-1:0] left_nxt;
	logic [RPT_W-1:0] acc_r;
	logic [RPT_W-1:0] acc_nxt;
	logic start_r;
	logic start_nxt;
	logic power_r;
	logic power_nxt;
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_s3_r;
	logic ext_rise;
	logic page_ok;
	logic ctrl_wr;
	logic pwr_wr;
	logic bit_wr;
	logic sw_start;
	logic trig;
	logic accept;
	logic pass_done;
	logic group_end;
	logic done_set;
	logic win_set;
	logic [RPT_W-1:0] rpt_eff;
	sac_src_t cm_nxt;
	sac_len_t pass_len;

	// pin crosses into the system clock before the edge detector sees it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end else begin
			ext_s1_r <= external_start_pin_i;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end
	assign ext_rise = ext_s2_r && !ext_s3_r;

	assign page_ok = (sfr_page_i == `SAC_CTRL_PAGE);
	assign ctrl_wr = sfr_wr_i && page_ok && sfr_addr_i == `SAC_CTRL_ADDR;
	assign pwr_wr = sfr_wr_i && page_ok && sfr_addr_i == `SAC_PWR_ADDR;
	// bit addresses of the control register share its upper five bits
	assign bit_wr = sfr_bit_wr_i && page_ok
		&& sfr_bit_addr_i[7:3] == `SAC_CTRL_ADDR >> 3;

	// 12-bit results are four 10-bit passes, timed as one 52-clock pass
	assign pass_len = mode_12bit_i ? `SAC_CLKS_12BIT
		: (mode_8bit_i ? `SAC_CLKS_8BIT : `SAC_CLKS_10BIT);

	// without burst every conversion ends its own group
	assign rpt_eff = (!ctrl_new[`SAC_BIT_BURST] || repeat_count_i == '0)
		? {{(RPT_W-1){1'b0}}, 1'b1} : repeat_count_i;

	// software's view of the settings; kept apart from the flags so that no loop forms
	always_comb begin
		ctrl_new = ctrl_r;
		sw_start = 1'b0;
		if (ctrl_wr) begin
			ctrl_new = sfr_wdata_i;
			sw_start = sfr_wdata_i[`SAC_BIT_BUSY];
		end else if (bit_wr) begin
			ctrl_new[sfr_bit_addr_i[2:0]] = sfr_bit_val_i;
			sw_start = sfr_bit_val_i && sfr_bit_addr_i[2:0] == 3'(`SAC_BIT_BUSY);
		end
		ctrl_new[`SAC_BIT_BUSY] = 1'b0;
		cm_nxt = ctrl_new[2:0];
	end

	always_comb begin
		ctrl_nxt = ctrl_new;
		// hardware set wins over a software clear in the same cycle
		if (done_set) begin
			ctrl_nxt[`SAC_BIT_DONE] = 1'b1;
		end
		if (win_set) begin
			ctrl_nxt[`SAC_BIT_WIN] = 1'b1;
		end
		lp_nxt = pwr_wr ? sfr_wdata_i[`SAC_BIT_LP] : lp_r;
	end

	always_comb begin
		case (ctrl_r[2:0])
			`SAC_CM_SW: trig = 1'b0;
			`SAC_CM_T0: trig = timer0_ovf_i;
			`SAC_CM_T2: trig = timer2_ovf_i;
			`SAC_CM_T3: trig = timer3_ovf_i;
			default: trig = ext_rise;
		endcase
		if (sw_start && cm_nxt == `SAC_CM_SW) begin
			trig = 1'b1;
		end
	end

	// triggers during a run are dropped; so are all with enable and burst off,
	// judged on the settings as written in the same cycle
	assign accept = trig && st_r == SAC_ST_IDLE
		&& (ctrl_new[`SAC_BIT_EN] || ctrl_new[`SAC_BIT_BURST]);
	assign group_end = pass_done && (acc_r + 1'b1 >= rpt_eff);
	assign done_set = group_end;
	assign win_set = group_end && acc_result_i >= greater_than_i
		&& acc_result_i <= less_than_i;

	always_comb begin
		st_nxt = st_r;
		left_nxt = left_r;
		acc_nxt = acc_r;
		start_nxt = 1'b0;
		case (st_r)
			SAC_ST_IDLE: begin
				if (accept) begin
					st_nxt = SAC_ST_CONV;
					start_nxt = 1'b1;
					// an external edge in burst still yields a single pass
					if (ctrl_new[`SAC_BIT_BURST] && ctrl_new[2] == 1'b0) begin
						left_nxt = rpt_eff - acc_r;
					end else begin
						left_nxt = {{(RPT_W-1){1'b0}}, 1'b1};
					end
				end
			end
			SAC_ST_CONV: begin
				if (pass_done) begin
					acc_nxt = group_end ? '0 : acc_r + 1'b1;
					left_nxt = left_r - 1'b1;
					if (left_r == {{(RPT_W-1){1'b0}}, 1'b1}) begin
						st_nxt = SAC_ST_IDLE;
					end else begin
						start_nxt = 1'b1;
					end
				end
			end
			default: begin
				st_nxt = SAC_ST_IDLE;
			end
		endcase
		power_nxt = ctrl_nxt[`SAC_BIT_EN] || st_nxt == SAC_ST_CONV;
	end

	always_comb begin
		rdata_nxt = rdata_r;
		if (sfr_rd_i) begin
			rdata_nxt = 8'h00;
			if (page_ok && sfr_addr_i == `SAC_CTRL_ADDR) begin
				rdata_nxt = ctrl_r;
			end else if (page_ok && sfr_addr_i == `SAC_PWR_ADDR) begin
				rdata_nxt = {lp_r, 7'h00};
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_r <= `SAC_CTRL_RESET;
			lp_r <= `SAC_PWR_RESET;
			rdata_r <= 8'h00;
			st_r <= SAC_ST_IDLE;
			left_r <= '0;
			acc_r <= '0;
			start_r <= 1'b0;
			power_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			lp_r <= lp_nxt;
			rdata_r <= rdata_nxt;
			st_r <= st_nxt;
			left_r <= left_nxt;
			acc_r <= acc_nxt;
			start_r <= start_nxt;
			power_r <= power_nxt;
		end
	end

	sac_pass_timer #(
		.LEN_W(6)
	) u_timer (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.start_i(start_r),
		.len_i(pass_len),
		.done_o(pass_done)
	);

	assign sfr_rdata_o = rdata_r;
	assign conv_start_o = start_r;
	assign converting_o = (st_r == SAC_ST_CONV);
	assign analog_power_o = power_r;
	assign low_power_select_o = lp_r;
	assign conversion_done_flag_o = ctrl_r[`SAC_BIT_DONE];
	assign window_hit_flag_o = ctrl_r[`SAC_BIT_WIN];

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_sw_start;
		sfr_wr_i && page_ok && sfr_addr_i == `SAC_CTRL_ADDR && st_r == SAC_ST_IDLE
			&& sfr_wdata_i[4] && sfr_wdata_i[2:0] == 3'h0
			&& (sfr_wdata_i[7] || sfr_wdata_i[6]);
	endsequence
	sequence s_ready;
		st_r == SAC_ST_IDLE && (ctrl_r[7] || ctrl_r[6]);
	endsequence

	property p_lp_write;
		pwr_wr |=> low_power_select_o == $past(sfr_wdata_i[7]);
	endproperty
	a_lp_write: assert property (p_lp_write) else $error("low power bit not taken");

	property p_sw_start;
		s_sw_start |-> ##1 conv_start_o && converting_o;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("software start missed");

	property p_t0_start;
		timer0_ovf_i && ctrl_r[2:0] == 3'h1 && !sfr_wr_i && !sfr_bit_wr_i
			and s_ready |=> conv_start_o;
	endproperty
	a_t0_start: assert property (p_t0_start) else $error("timer 0 start missed");

	property p_no_start_off;
		conv_start_o && !$past(converting_o) |-> ctrl_r[7] || ctrl_r[6];
	endproperty
	a_no_start_off: assert property (p_no_start_off) else $error("start while disabled");

	property p_power;
		analog_power_o == (ctrl_r[7] || converting_o);
	endproperty
	a_power: assert property (p_power) else $error("power state wrong");

	property p_done_cause;
		$rose(conversion_done_flag_o) && !$past(ctrl_wr || bit_wr) |-> $past(pass_done);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done flag without pass end");

	property p_done_set;
		group_end |=> conversion_done_flag_o;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done flag not set");

	property p_win_group;
		win_set |-> acc_r + 1'b1 >= rpt_eff ##1 window_hit_flag_o;
	endproperty
	a_win_group: assert property (p_win_group) else $error("window before full count");

	property p_burst_next;
		pass_done && converting_o && left_r > 1 |=> conv_start_o;
	endproperty
	a_burst_next: assert property (p_burst_next) else $error("burst pass not chained");

	property p_busy_reads_zero;
		sfr_rd_i |=> !sfr_rdata_o[4];
	endproperty
	a_busy_reads_zero: assert property (p_busy_reads_zero) else $error("busy bit read as one");
endmodule

//--- testbench/sac_analog_model.sv
// behavioural model of the analog core and of the trigger sources
`timescale 1ns/1ps
module sac_analog_model (
	input wire logic clk_sys_i,
	input wire logic conv_start_i,
	input wire logic converting_i,
	input wire logic [3:0] fire_i,
	input wire logic [15:0] value_i,
	output logic timer0_ovf_o,
	output logic timer2_ovf_o,
	output logic timer3_ovf_o,
	output logic external_start_pin_o,
	output logic [15:0] acc_result_o
);
	logic [15:0] held = 16'h0000;
	initial {external_start_pin_o, timer3_ovf_o, timer2_ovf_o, timer0_ovf_o} = 4'h0;
	// overflows are one-cycle pulses, the pin rises and falls again
	always @(posedge clk_sys_i) begin
		{external_start_pin_o, timer3_ovf_o, timer2_ovf_o, timer0_ovf_o} <= fire_i;
		if (conv_start_i) begin
			held <= value_i;
		end
	end
	// outside a pass the result is not valid, so show its inverse
	assign acc_result_o = converting_i ? held : ~held;
endmodule

//--- testbench/test_sac_conv_ctrl.sv
// self-checking bench of the conversion control block
`timescale 1ns/1ps
module test_sac_conv_ctrl;
	import sac_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, bit_addr = 8'h00, rdata;
	logic [3:0] page = 4'h0, fire = 4'h0, sel;
	logic wr = 1'b0, rd = 1'b0, bit_wr = 1'b0, bit_val = 1'b0, m8 = 1'b0, m12 = 1'b0;
	logic [6:0] rpt = 7'h01;
	logic [15:0] value = 16'h0100, gt = 16'h0100, lt = 16'h0100, acc;
	logic t0, t2, t3, pin, start, busy, pwr, lp, done, win;
	int failures = 0, comparisons = 0, n, s;
	int lens[3] = '{11, 13, 52};
	always #25 clk_sys_i = ~clk_sys_i;
	sac_conv_ctrl i_dut (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.sfr_addr_i(addr), .sfr_page_i(page), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
		.sfr_rd_i(rd), .sfr_bit_wr_i(bit_wr), .sfr_bit_addr_i(bit_addr),
		.sfr_bit_val_i(bit_val), .timer0_ovf_i(t0), .timer2_ovf_i(t2),
		.timer3_ovf_i(t3), .external_start_pin_i(pin), .mode_8bit_i(m8),
		.mode_12bit_i(m12), .repeat_count_i(rpt), .acc_result_i(acc),
		.greater_than_i(gt), .less_than_i(lt), .sfr_rdata_o(rdata),
		.conv_start_o(start), .converting_o(busy), .analog_power_o(pwr),
		.low_power_select_o(lp), .conversion_done_flag_o(done), .window_hit_flag_o(win)
	);
	sac_analog_model i_model (
		.clk_sys_i(clk_sys_i), .conv_start_i(start), .converting_i(busy),
		.fire_i(fire), .value_i(value), .timer0_ovf_o(t0), .timer2_ovf_o(t2),
		.timer3_ovf_o(t3), .external_start_pin_o(pin), .acc_result_o(acc)
	);
	task automatic results();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// every call returns 1 ns after a rising edge
	task automatic step(input int k);
		repeat (k) @(posedge clk_sys_i);
		#1;
	endtask
	// each access lets an edge pass first, so back-to-back calls never retoggle a strobe
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		step(1);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
	endtask
	task automatic bit_set(input logic [2:0] b, input logic v);
		step(1);
		bit_addr = {5'h1D, b};
		bit_val = v;
		bit_wr = 1'b1;
		step(1);
		bit_wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e);
		step(1);
		addr = a;
		page = p;
		rd = 1'b1;
		step(1);
		rd = 1'b0;
		page = 4'h0;
		chk(rdata, e);
	endtask
	task automatic fire_pulse(input logic [3:0] f);
		step(1);
		fire = f;
		step(1);
		fire = 4'h0;
	endtask
	// counts cycles and pass starts until the done flag rises
	task automatic wait_done(input int bound);
		s = 0;
		for (n = 0; n < bound; n++) begin
			if (start === 1'b1) s++;
			if (done === 1'b1) break;
			chk(win, 1'b0);
			step(1);
		end
		if (n == bound) begin
			failures++;
			$display("FAIL at %0t: timeout after %h cycles, bound %h", $time, n, bound);
			results();
		end
	endtask
	initial begin
		step(2);
		rst_n_i = 1'b1;
		rd_chk(8'hE8, 4'h0, 8'h00);
		rd_chk(8'hBB, 4'h0, 8'h00);
		rd_chk(8'hE8, 4'h1, 8'h00);
		rd_chk(8'h55, 4'h0, 8'h00);
		wr_reg(8'hBB, 8'hFF);
		rd_chk(8'hBB, 4'h0, 8'h80);
		chk(lp, 1'b1);
		for (int r = 0; r < 3; r++) begin
			m8 = (r == 0);
			m12 = (r == 2);
			// lower bound one above the result in 10-bit mode
			gt = (r == 1) ? 16'h0101 : 16'h0100;
			wr_reg(8'hE8, 8'h90);
			chk(start, 1'b1);
			chk(pwr, 1'b1);
			wait_done(200);
			chk(16'(n), 16'(lens[r] + 2));
			chk(16'(s), 16'h0001);
			chk(win, r != 1);
			rd_chk(8'hE8, 4'h0, (r != 1) ? 8'hA8 : 8'hA0);
			wr_reg(8'hE8, 8'h80);
			rd_chk(8'hE8, 4'h0, 8'h80);
		end
		m8 = 1'b0;
		m12 = 1'b0;
		gt = 16'h0100;
		wr_reg(8'hE8, 8'h10);
		step(3);
		chk(busy, 1'b0);
		wr_reg(8'hE8, 8'h91);
		step(3);
		chk(busy, 1'b0);
		for (int cm = 1; cm < 5; cm++) begin
			sel = 4'h1 << (cm - 1);
			wr_reg(8'hE8, 8'h80 | 8'(cm));
			fire_pulse({sel[2:0], sel[3]});
			step(5);
			chk(busy, 1'b0);
			fire_pulse(sel);
			wait_done(100);
			chk(16'(s), 16'h0001);
			wr_reg(8'hE8, 8'h80);
		end
		rpt = 7'h03;
		wr_reg(8'hE8, 8'h50);
		wait_done(300);
		chk(16'(s), 16'h0003);
		step(2);
		chk(pwr, 1'b0);
		wr_reg(8'hE8, 8'hD0);
		wait_done(300);
		chk(16'(s), 16'h0003);
		step(2);
		chk(pwr, 1'b1);
		bit_set(3'h5, 1'b0);
		bit_set(3'h3, 1'b0);
		rd_chk(8'hE8, 4'h0, 8'hC0);
		bit_set(3'h6, 1'b0);
		bit_set(3'h4, 1'b1);
		wait_done(100);
		chk(16'(s), 16'h0001);
		rd_chk(8'hE8, 4'h0, 8'hA8);
		results();
	end
endmodule
